// File: verilog/wpt_phase_ctrl.sv
// transmitter phase controller: enable, reset, thermal, coils, packets
//
// What this block does
// - supply good and enable low start power-up: reference, regulators, buck on.
// - shut down above hot threshold, resume only below cool threshold.
// - commanded frequency stays 110-205 kHz; power set only by frequency.
// - act on receiver packets: raise, lower power or end transfer.
// - demodulate filtered comm input into bytes and decode each packet.
// - read trim word from the one-time store before operation; later words only addressed.
// - reach external memory over I2C clock and data, as initiator.
// - at most one coil-select output asserted at a time; none between selection rounds and when hot.
// - external reset high forces all state to defaults.
// - on reset release, begin with the fetch from external memory.
// - enable input high suspends into sleep; low means active.
// - phases run selection, ping, identification/configuration, power.
// - selection bursts each coil in turn at regular intervals, listening.
// - the coil that answered stays selected through ping, id/config and power.
// - ping drives fixed 175 kHz at 50 percent duty.
// - no strength packet in ping removes power after delay; else id/config.
// - bad or late configuration sequence ends power, back to selection.
`timescale 1ns/10ps
`default_nettype none
module wpt_phase_ctrl #(
  parameter int unsigned SEL_CYC  = wpt_pkg::SEL_CYC,
  parameter int unsigned PING_CYC = wpt_pkg::PING_CYC,
  parameter int unsigned PKT_CYC  = wpt_pkg::PKT_CYC,
  parameter int unsigned BIT_CYC  = wpt_pkg::BIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ext_reset,
  input  wire logic        enable_n,
  input  wire logic        undervoltage_lockout,
  input  wire logic        over_temp_hi,
  input  wire logic        temp_below_lo,
  input  wire logic        filtered_comm_input,
  input  wire logic        coil_response,
  input  wire logic [7:0]  otp_data,
  output logic [1:0]       otp_addr,
  output logic             power_up_en,
  output logic             sleep,
  output logic             coil_select_first,
  output logic             coil_select_second,
  output logic             coil_select_third,
  output logic [7:0]       freq_khz,
  output logic [7:0]       duty,
  output logic             inverter_switch_node,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic [7:0]       trim,
  output logic [7:0]       mem_word,
  output logic [2:0]       phase
);
  typedef struct packed {
    logic [2:0]  s_res;
    logic [2:0]  s_en;
    logic [2:0]  s_uv;
    logic [2:0]  s_hot;
    logic [2:0]  s_cool;
    logic [2:0]  s_comm;
    logic [2:0]  s_resp;
    logic [2:0]  s_sda;
    wpt_pkg::phase_t ph;
    wpt_pkg::inv_cmd_t cmd;
    logic        pwr;
    logic        slp;
    logic [1:0]  otp_a;
    logic [7:0]  trim_w;
    logic [31:0] tmr;
    logic [1:0]  coil_idx;
    logic        bursting;
    logic [16:0] bit_tmr;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic [1:0]  byte_no;
    logic [7:0]  hdr;
    logic [7:0]  msg;
    logic [7:0]  csum;
    logic        in_pkt;
    logic [2:0]  cfg_step;
    logic [3:0]  opt_cnt;
    logic        ext_req;
    logic [8:0]  i2c_div;
    logic [5:0]  i2c_step;
    logic        i2c_done;
    logic        scl;
    logic        sda;
    logic        sda_en;
    logic [7:0]  mword;
    logic        nco;
    logic [15:0] nco_cnt;
  } st_t;

  st_t st_ff;
  st_t nxt_st;
  wpt_pkg::packet_t pkt;

  function automatic logic [7:0] clamp_freq(input logic [8:0] f);
    if (f < 9'(wpt_pkg::FREQ_MIN_KHZ)) return 8'(wpt_pkg::FREQ_MIN_KHZ);
    if (f > 9'(wpt_pkg::FREQ_MAX_KHZ)) return 8'(wpt_pkg::FREQ_MAX_KHZ);
    return f[7:0];
  endfunction

  function automatic logic [2:0] onehot(input logic [1:0] i);
    return (i == 2'd0) ? 3'b001 : (i == 2'd1) ? 3'b010 : 3'b100;
  endfunction

  // i2c initiator: start, device byte read, one data byte, nack, stop
  function automatic logic [1:0] i2c_bit(input logic [5:0] s,
                                         input logic [6:0] a);
    if (s == 6'd0) return 2'b10;
    if (s <= 6'd7) return {1'b1, a[3'(7 - s)]};
    if (s == 6'd19) return 2'b10;
    return 2'b11;
  endfunction

  logic [31:0] half_cyc;
  logic        ph_end;

  always_comb begin
    logic [8:0]  f9;
    logic [7:0]  byte_v;
    logic        byte_rdy;
    logic [1:0]  ib;
    nxt_st = st_ff;
    f9 = 9'h000;
    byte_v = 8'h00;
    byte_rdy = 1'b0;
    ib = 2'b00;
    pkt = '0;
    half_cyc = 32'h0;
    ph_end = 1'b0;
    nxt_st.s_res  = {st_ff.s_res[1:0], ext_reset};
    nxt_st.s_en   = {st_ff.s_en[1:0], enable_n};
    nxt_st.s_uv   = {st_ff.s_uv[1:0], undervoltage_lockout};
    nxt_st.s_hot  = {st_ff.s_hot[1:0], over_temp_hi};
    nxt_st.s_cool = {st_ff.s_cool[1:0], temp_below_lo};
    nxt_st.s_comm = {st_ff.s_comm[1:0], filtered_comm_input};
    nxt_st.s_resp = {st_ff.s_resp[1:0], coil_response};
    nxt_st.s_sda  = {st_ff.s_sda[1:0], sda_i};
    nxt_st.tmr = st_ff.tmr + 32'h1;

    // demodulator: idle-high line, start bit low, 8 data bits lsb first
    if (st_ff.bitcnt == 4'h0) begin
      if (!st_ff.s_comm[1] && st_ff.s_comm[2]) begin
        nxt_st.bitcnt = 4'h1;
        nxt_st.bit_tmr = 17'(BIT_CYC + BIT_CYC / 2 - 2);
      end
    end else if (st_ff.bit_tmr == 17'h0) begin
      nxt_st.shreg = {st_ff.s_comm[1], st_ff.shreg[7:1]};
      nxt_st.bit_tmr = 17'(BIT_CYC - 1);
      nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
      if (st_ff.bitcnt == 4'h8) begin
        byte_v = {st_ff.s_comm[1], st_ff.shreg[7:1]};
        byte_rdy = 1'b1;
        nxt_st.bitcnt = 4'h0;
      end
    end else begin
      nxt_st.bit_tmr = st_ff.bit_tmr - 17'h1;
    end

    // packet framing: header, one message byte, checksum
    if (byte_rdy) begin
      nxt_st.csum = st_ff.csum ^ byte_v;
      unique case (st_ff.byte_no)
        2'd0: begin
          nxt_st.hdr = byte_v;
          nxt_st.csum = byte_v;
          nxt_st.byte_no = 2'd1;
        end
        2'd1: begin
          nxt_st.msg = byte_v;
          nxt_st.byte_no = 2'd2;
        end
        default: begin
          pkt.valid = 1'b1;
          pkt.header = st_ff.hdr;
          pkt.msg0 = st_ff.msg;
          pkt.ok = ((st_ff.csum ^ byte_v) == 8'h00);
          nxt_st.byte_no = 2'd0;
        end
      endcase
    end

    // frequency generator for the inverter drive
    half_cyc = wpt_pkg::CLK_HZ / 2000 / 32'(st_ff.cmd.freq_khz | 8'h01);
    if (st_ff.cmd.drive_on) begin
      if (st_ff.nco_cnt >= 16'(half_cyc) - 16'h1) begin
        nxt_st.nco_cnt = 16'h0;
        nxt_st.nco = !st_ff.nco;
      end else begin
        nxt_st.nco_cnt = st_ff.nco_cnt + 16'h1;
      end
    end else begin
      nxt_st.nco = 1'b0;
    end

    if (st_ff.s_hot[2] && st_ff.ph != wpt_pkg::PH_OFF
        && st_ff.ph != wpt_pkg::PH_BOOT) begin
      nxt_st.ph = wpt_pkg::PH_HOT;
      nxt_st.cmd = '0;
      nxt_st.pwr = 1'b0;
    end else if (st_ff.s_en[2] || st_ff.s_uv[2]) begin
      nxt_st.ph = wpt_pkg::PH_OFF;
      nxt_st.slp = st_ff.s_en[2];
      nxt_st.pwr = 1'b0;
      nxt_st.cmd = '0;
      nxt_st.i2c_done = 1'b0;
      nxt_st.i2c_step = 6'h0;
      nxt_st.scl = 1'b1;
      nxt_st.sda_en = 1'b0;
    end else begin
      unique case (st_ff.ph)
        wpt_pkg::PH_OFF: begin
          nxt_st.slp = 1'b0;
          nxt_st.pwr = 1'b1;
          nxt_st.otp_a = 2'd0;
          nxt_st.ph = wpt_pkg::PH_BOOT;
        end
        wpt_pkg::PH_BOOT: begin
          if (st_ff.otp_a == 2'd0) nxt_st.trim_w = otp_data;
          if (st_ff.otp_a != 2'(wpt_pkg::OTP_WORDS - 1))
            nxt_st.otp_a = st_ff.otp_a + 2'd1;
          // external memory fetch after reset release
          // data moves in the same cycle that scl is pulled low; start and stop while high
          if (!st_ff.i2c_done) begin
            if (st_ff.i2c_div == 9'(wpt_pkg::I2C_DIV)) begin
              nxt_st.i2c_div = 9'h0;
              if (!st_ff.scl) begin
                nxt_st.scl = 1'b1;
              end else if (st_ff.i2c_step == 6'd0 && !st_ff.sda_en) begin
                nxt_st.sda_en = 1'b1;
              end else if (st_ff.i2c_step == 6'd19) begin
                nxt_st.sda_en = 1'b0;
                nxt_st.i2c_done = 1'b1;
              end else begin
                if (st_ff.i2c_step >= 6'd10 && st_ff.i2c_step <= 6'd17)
                  nxt_st.mword = {st_ff.mword[6:0], st_ff.s_sda[2]};
                ib = i2c_bit(st_ff.i2c_step + 6'h1, wpt_pkg::MEM_DEV_ADDR);
                nxt_st.sda_en = !ib[0];
                nxt_st.scl = 1'b0;
                nxt_st.i2c_step = st_ff.i2c_step + 6'h1;
              end
            end else begin
              nxt_st.i2c_div = st_ff.i2c_div + 9'h1;
            end
          end
          if (st_ff.i2c_done && st_ff.otp_a == 2'(wpt_pkg::OTP_WORDS - 1))
          begin
            nxt_st.ph = wpt_pkg::PH_SELECT;
            nxt_st.sda_en = 1'b0;
            nxt_st.tmr = 32'h0;
          end
        end
        wpt_pkg::PH_SELECT: begin
          nxt_st.cmd.freq_khz = 8'(wpt_pkg::FREQ_PING_KHZ);
          nxt_st.cmd.duty = wpt_pkg::DUTY_PING;
          if (!st_ff.bursting && st_ff.tmr >= 32'(SEL_CYC)) begin
            nxt_st.tmr = 32'h0;
            nxt_st.bursting = 1'b1;
            nxt_st.coil_idx = 2'd0;
          end
          if (st_ff.bursting) begin
            nxt_st.cmd.coil_sel = onehot(st_ff.coil_idx);
            nxt_st.cmd.drive_on = 1'b1;
            if (st_ff.s_resp[2]) begin
              nxt_st.ph = wpt_pkg::PH_PING;
              nxt_st.bursting = 1'b0;
              nxt_st.tmr = 32'h0;
              nxt_st.byte_no = 2'd0;
            end else if (st_ff.tmr >= 32'(wpt_pkg::BURST_CYC)) begin
              nxt_st.tmr = 32'h0;
              nxt_st.cmd.drive_on = 1'b0;
              if (st_ff.coil_idx == 2'd2) begin
                nxt_st.bursting = 1'b0;
                nxt_st.cmd.coil_sel = 3'b000;
              end else begin
                nxt_st.coil_idx = st_ff.coil_idx + 2'd1;
              end
            end
          end
        end
        wpt_pkg::PH_PING: begin
          nxt_st.cmd.freq_khz = 8'(wpt_pkg::FREQ_PING_KHZ);
          nxt_st.cmd.duty = wpt_pkg::DUTY_PING;
          nxt_st.cmd.drive_on = 1'b1;
          if (pkt.valid && pkt.ok && pkt.header == wpt_pkg::HDR_STRENGTH)
          begin
            nxt_st.ph = wpt_pkg::PH_IDCFG;
            nxt_st.tmr = 32'h0;
            nxt_st.cfg_step = 3'd0;
            nxt_st.opt_cnt = 4'h0;
          end else if (st_ff.tmr >= 32'(PING_CYC) && st_ff.bitcnt == 4'h0
                       && st_ff.byte_no == 2'd0) begin
            ph_end = 1'b1;
          end
        end
        wpt_pkg::PH_IDCFG: begin
          if (pkt.valid) begin
            nxt_st.tmr = 32'h0;
            if (!pkt.ok) ph_end = 1'b1;
            else if (st_ff.cfg_step == 3'd0) begin
              if (pkt.header == wpt_pkg::HDR_ID) begin
                nxt_st.ext_req = pkt.msg0[wpt_pkg::EXT_BIT_POS];
                nxt_st.cfg_step = 3'd1;
              end else ph_end = 1'b1;
            end else if (st_ff.cfg_step == 3'd1 && st_ff.ext_req) begin
              if (pkt.header == wpt_pkg::HDR_EXT_ID) begin
                nxt_st.ext_req = 1'b0;
              end else ph_end = 1'b1;
            end else if (pkt.header == wpt_pkg::HDR_CONFIG) begin
              nxt_st.ph = wpt_pkg::PH_POWER;
            end else if (st_ff.opt_cnt < wpt_pkg::MAX_OPT_CFG
                         && pkt.header != wpt_pkg::HDR_STRENGTH
                         && pkt.header != wpt_pkg::HDR_ID) begin
              nxt_st.opt_cnt = st_ff.opt_cnt + 4'h1;
            end else ph_end = 1'b1;
          end else if (st_ff.tmr >= 32'(PKT_CYC)) begin
            ph_end = 1'b1;
          end
        end
        wpt_pkg::PH_POWER: begin
          if (pkt.valid) begin
            nxt_st.tmr = 32'h0;
            if (!pkt.ok || pkt.header == wpt_pkg::HDR_END) ph_end = 1'b1;
            else if (pkt.header == wpt_pkg::HDR_CTRL_ERR) begin
              // positive error means more power: lower frequency
              f9 = 9'({1'b0, st_ff.cmd.freq_khz})
                 - 9'({{4{pkt.msg0[7]}}, pkt.msg0[7:3]});
              if (pkt.msg0[7] && f9 > 9'(wpt_pkg::FREQ_MAX_KHZ))
                f9 = 9'(wpt_pkg::FREQ_MAX_KHZ);
              if (!pkt.msg0[7] && f9 > {1'b0, st_ff.cmd.freq_khz})
                f9 = 9'(wpt_pkg::FREQ_MIN_KHZ);
              nxt_st.cmd.freq_khz = clamp_freq(f9);
            end
          end else if (st_ff.tmr >= 32'(PKT_CYC)) begin
            ph_end = 1'b1;
          end
        end
        wpt_pkg::PH_HOT: begin
          nxt_st.cmd = '0;
          if (st_ff.s_cool[2]) begin
            nxt_st.ph = wpt_pkg::PH_SELECT;
            nxt_st.pwr = 1'b1;
            nxt_st.tmr = 32'h0;
            nxt_st.bursting = 1'b0;
          end
        end
        default: nxt_st.ph = wpt_pkg::PH_OFF;
      endcase
      if (ph_end) begin
        nxt_st.ph = wpt_pkg::PH_SELECT;
        nxt_st.cmd = '0;
        nxt_st.tmr = 32'h0;
        nxt_st.bursting = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || st_ff.s_res[2]) begin
      st_ff <= '0;
      st_ff.s_en <= 3'b111;
      st_ff.s_uv <= 3'b111;
      st_ff.s_res <= {st_ff.s_res[1:0], ext_reset};
      st_ff.s_comm <= 3'b111;
      st_ff.s_sda <= 3'b111;
      st_ff.scl <= 1'b1;
      st_ff.slp <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || st_ff.s_res[2]) begin
      {coil_select_first, coil_select_second, coil_select_third} <= 3'b000;
      freq_khz <= 8'h00;
      duty <= 8'h00;
      inverter_switch_node <= 1'b0;
      power_up_en <= 1'b0;
      sleep <= 1'b1;
      scl_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      trim <= 8'h00;
      mem_word <= 8'h00;
      phase <= 3'b000;
      otp_addr <= 2'd0;
    end else begin
      {coil_select_third, coil_select_second, coil_select_first}
        <= nxt_st.cmd.coil_sel;
      freq_khz <= nxt_st.cmd.freq_khz;
      duty <= nxt_st.cmd.duty;
      inverter_switch_node <= nxt_st.nco && nxt_st.cmd.drive_on;
      power_up_en <= nxt_st.pwr;
      sleep <= nxt_st.slp;
      scl_o <= 1'b0;
      scl_oe <= !nxt_st.scl;
      sda_o <= 1'b0;
      sda_oe <= nxt_st.sda_en;
      trim <= nxt_st.trim_w;
      mem_word <= nxt_st.mword;
      phase <= nxt_st.ph;
      otp_addr <= nxt_st.otp_a;
    end
  end
endmodule // wpt_phase_ctrl
`default_nettype wire

// File: verilog/wpt_pkg.sv
// package: constants and carrier types for the transmitter phase controller
package wpt_pkg;
  localparam int unsigned CLK_HZ          = 125000000;
  localparam int unsigned FREQ_MIN_KHZ    = 110;
  localparam int unsigned FREQ_MAX_KHZ    = 205;
  localparam int unsigned FREQ_PING_KHZ   = 175;
  localparam logic [7:0]  DUTY_PING       = 8'h80;
  localparam logic [7:0]  HDR_STRENGTH    = 8'h01;
  localparam logic [7:0]  HDR_END         = 8'h02;
  localparam logic [7:0]  HDR_CTRL_ERR    = 8'h03;
  localparam logic [7:0]  HDR_RECT_PWR    = 8'h04;
  localparam logic [7:0]  HDR_HOLDOFF     = 8'h06;
  localparam logic [7:0]  HDR_ID          = 8'h71;
  localparam logic [7:0]  HDR_EXT_ID      = 8'h81;
  localparam logic [7:0]  HDR_CONFIG      = 8'h51;
  localparam logic [3:0]  MAX_OPT_CFG     = 4'h7;
  localparam int unsigned EXT_BIT_POS     = 7;
  localparam int unsigned TEMP_HI_C       = 140;
  localparam int unsigned TEMP_LO_C       = 110;
  localparam int unsigned BIT_US          = 500;
  localparam int unsigned BIT_CYC         = CLK_HZ / 1000000 * BIT_US;
  localparam int unsigned SEL_INTERVAL_MS = 400;
  localparam int unsigned BURST_US        = 70;
  localparam int unsigned PING_WAIT_MS    = 65;
  localparam int unsigned PKT_TIMEOUT_MS  = 1800;
  localparam int unsigned SEL_CYC   = CLK_HZ / 1000 * SEL_INTERVAL_MS;
  localparam int unsigned BURST_CYC = CLK_HZ / 1000000 * BURST_US;
  localparam int unsigned PING_CYC  = CLK_HZ / 1000 * PING_WAIT_MS;
  localparam int unsigned PKT_CYC   = CLK_HZ / 1000 * PKT_TIMEOUT_MS;
  localparam int unsigned OTP_WORDS = 4;
  localparam logic [6:0]  MEM_DEV_ADDR = 7'h50;
  localparam int unsigned I2C_DIV   = 312;

  typedef enum logic [2:0] {
    PH_OFF    = 3'b000,
    PH_BOOT   = 3'b001,
    PH_SELECT = 3'b010,
    PH_PING   = 3'b011,
    PH_IDCFG  = 3'b100,
    PH_POWER  = 3'b101,
    PH_HOT    = 3'b110
  } phase_t;

  typedef struct packed {
    logic [2:0] coil_sel;
    logic [7:0] freq_khz;
    logic [7:0] duty;
    logic       drive_on;
  } inv_cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] header;
    logic [7:0] msg0;
    logic       ok;
  } packet_t;
endpackage

// File: sim/wpt_phase_ctrl_checker.sv
// checker: port properties of the transmitter phase controller
`timescale 1ns/10ps
`default_nettype none
module wpt_phase_ctrl_checker (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       ext_reset,
  input wire logic       enable_n,
  input wire logic       over_temp_hi,
  input wire logic       power_up_en,
  input wire logic       sleep,
  input wire logic       coil_select_first,
  input wire logic       coil_select_second,
  input wire logic       coil_select_third,
  input wire logic [7:0] freq_khz,
  input wire logic [7:0] duty,
  input wire logic       scl_o,
  input wire logic       sda_o,
  input wire logic [2:0] phase
);
  logic [2:0] coils;
  logic       linked;
  assign coils = {coil_select_third, coil_select_second, coil_select_first};
  assign linked = phase inside {wpt_pkg::PH_PING, wpt_pkg::PH_IDCFG,
                                wpt_pkg::PH_POWER};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_one_coil_only: assert property ($onehot0(coils))
    else $error("more than one coil selected");
  a_freq_in_range: assert property (
    freq_khz != 8'h00 |-> freq_khz >= 8'h6e && freq_khz <= 8'hcd)
    else $error("frequency out of range");
  a_ping_fixed_point: assert property (
    phase == wpt_pkg::PH_PING && $past(phase) == wpt_pkg::PH_PING
    |-> freq_khz == 8'haf && duty == wpt_pkg::DUTY_PING)
    else $error("ping operating point wrong");
  a_coil_held: assert property (linked && $past(linked) |-> $stable(coils))
    else $error("coil changed after answer");
  a_sleep_follows: assert property (enable_n [*8] |-> sleep)
    else $error("no sleep while disabled");
  a_active_powered: assert property (
    phase inside {wpt_pkg::PH_SELECT, wpt_pkg::PH_PING, wpt_pkg::PH_IDCFG,
                  wpt_pkg::PH_POWER} |-> power_up_en && !sleep)
    else $error("active phase without power");
  a_ext_reset_clears: assert property (
    ext_reset [*6] |-> phase == wpt_pkg::PH_OFF && coils == 3'h0)
    else $error("external reset did not clear");
  a_hot_entry: assert property (
    (over_temp_hi && linked) [*8] |-> phase == wpt_pkg::PH_HOT)
    else $error("no shutdown when hot");
  a_hot_no_coils: assert property (
    phase == wpt_pkg::PH_HOT |-> coils == 3'h0)
    else $error("coil selected while hot");
  a_hot_exit: assert property (
    $past(phase) == wpt_pkg::PH_HOT && phase != wpt_pkg::PH_HOT
    |-> phase inside {wpt_pkg::PH_SELECT, wpt_pkg::PH_OFF})
    else $error("thermal recovery not to selection");
  a_open_drain_low: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("open drain line driven high");
  c_power: cover property (phase == wpt_pkg::PH_POWER);
  c_hot: cover property (phase == wpt_pkg::PH_HOT);
  c_ping_lost: cover property (
    phase == wpt_pkg::PH_PING ##1 phase == wpt_pkg::PH_SELECT);
endmodule // wpt_phase_ctrl_checker
`default_nettype wire

// File: sim/rx_partner.sv
// receiver model: coil answer and packet bit stream on the comm line
`timescale 1ns/10ps
`default_nettype none
module rx_partner #(
  parameter int unsigned BIT_CYC = 16
) (
  input  wire logic       clk,
  input  wire logic [2:0] coils,
  input  wire logic [2:0] ans_mask,
  output logic            coil_response,
  output logic            comm_line
);
  assign coil_response = |(coils & ans_mask);
  initial comm_line = 1'b1;
  task automatic send_bit(input logic b);
    comm_line = b;
    repeat (BIT_CYC) @(negedge clk);
  endtask
  task automatic send_byte(input logic [7:0] v);
    send_bit(1'b0);
    for (int i = 0; i < 8; i++) send_bit(v[i]);
    send_bit(1'b1);
  endtask
  // idle-high preamble, header, message, checksum; bad flips checksum
  task automatic send_packet(input logic [7:0] hdr, input logic [7:0] msg,
                             input logic bad);
    repeat (4) send_bit(1'b1);
    send_byte(hdr);
    send_byte(msg);
    send_byte(hdr ^ msg ^ {7'h00, bad});
  endtask
endmodule // rx_partner
`default_nettype wire

// File: sim/wpt_phase_ctrl_test.sv
// testbench: phase sequencing, packets, thermal, reset and sleep
`timescale 1ns/10ps
`default_nettype none
module wpt_phase_ctrl_test;
  logic        clk, rst_n, ext_reset, enable_n, undervoltage_lockout;
  logic        over_temp_hi, temp_below_lo, comm_line, coil_response;
  logic        power_up_en, sleep, scl_o, scl_oe, sda_o, sda_oe, sw_node;
  logic [1:0]  otp_addr;
  logic [2:0]  coils, phase, ans_mask;
  logic [7:0]  otp_data, freq_khz, duty, trim, mem_word;
  int          bad_count, checks_done, n;
  logic [7:0]  otp_mem [4] = '{8'h5a, 8'h3c, 8'h00, 8'hff};
  // control error byte, frequency expected after it (start 175 kHz)
  logic [15:0] rows [11] = '{16'h40a7, 16'hc0af, 16'h80bf, 16'h80cd,
    16'h7fbe, 16'h7faf, 16'h7fa0, 16'h7f91, 16'h7f82, 16'h7f73, 16'h7f6e};
  assign otp_data = otp_mem[otp_addr];
  wpt_phase_ctrl #(.SEL_CYC(2000), .PING_CYC(4000), .PKT_CYC(20000),
                   .BIT_CYC(16)) dut_u (
    .clk, .rst_n, .ext_reset, .enable_n, .undervoltage_lockout,
    .over_temp_hi, .temp_below_lo, .filtered_comm_input(comm_line),
    .coil_response, .otp_data, .otp_addr, .power_up_en, .sleep,
    .coil_select_first(coils[0]), .coil_select_second(coils[1]),
    .coil_select_third(coils[2]), .freq_khz, .duty,
    .inverter_switch_node(sw_node), .scl_o, .scl_oe, .sda_i(~sda_oe), .sda_o,
    .sda_oe, .trim, .mem_word, .phase);
  rx_partner #(.BIT_CYC(16)) partner_u (
    .clk, .coils, .ans_mask, .coil_response, .comm_line);
  task automatic expect_eq(input logic [7:0] got, input logic [7:0] exp,
                           input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_phase(input logic [2:0] p, input int lim,
                            output int cyc);
    cyc = 0;
    while (phase !== p && cyc < lim) begin
      @(negedge clk);
      cyc++;
    end
    expect_eq({5'h00, phase}, {5'h00, p}, "phase");
  endtask
  task automatic wait_level(input logic v, inout int cyc);
    while (sw_node !== v && cyc < 800) begin
      @(negedge clk);
      cyc++;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (65000) @(posedge clk);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict;
  end
  initial begin
    rst_n = 1'b0;
    ext_reset = 1'b0;
    enable_n = 1'b0;
    undervoltage_lockout = 1'b1;
    over_temp_hi = 1'b0;
    temp_below_lo = 1'b1;
    ans_mask = 3'h0;
    bad_count = 0;
    checks_done = 0;
    repeat (16) @(negedge clk);
    expect_eq({7'h00, sleep}, 8'h01, "sleep in reset");
    expect_eq({5'h00, phase}, 8'h00, "phase in reset");
    rst_n = 1'b1;
    repeat (20) @(negedge clk);
    expect_eq({7'h00, power_up_en}, 8'h00, "low supply held off");
    $display("test reset done");
    undervoltage_lockout = 1'b0;
    wait_phase(wpt_pkg::PH_SELECT, 90000, n);
    expect_eq({7'h00, power_up_en}, 8'h01, "power up");
    expect_eq(trim, otp_mem[0], "trim word");
    expect_eq(mem_word, 8'hff, "idle bus read");
    $display("test boot done");
    ans_mask = 3'h4;
    wait_phase(wpt_pkg::PH_PING, 25000, n);
    repeat (2) @(negedge clk);
    expect_eq({5'h00, coils}, 8'h04, "answering coil");
    expect_eq(freq_khz, 8'haf, "ping frequency");
    expect_eq(duty, wpt_pkg::DUTY_PING, "ping duty");
    n = 0;
    wait_level(1'b1, n);
    wait_level(1'b0, n);
    n = 0;
    wait_level(1'b1, n);
    expect_eq({7'h00, n >= 355 && n <= 360}, 8'h01, "ping half period");
    partner_u.send_packet(wpt_pkg::HDR_STRENGTH, 8'h80, 1'b0);
    wait_phase(wpt_pkg::PH_IDCFG, 200, n);
    partner_u.send_packet(wpt_pkg::HDR_ID, 8'h80, 1'b0);
    partner_u.send_packet(wpt_pkg::HDR_EXT_ID, 8'h00, 1'b0);
    partner_u.send_packet(wpt_pkg::HDR_HOLDOFF, 8'h00, 1'b0);
    expect_eq(freq_khz, 8'haf, "operating point kept");
    partner_u.send_packet(wpt_pkg::HDR_CONFIG, 8'h00, 1'b0);
    wait_phase(wpt_pkg::PH_POWER, 200, n);
    expect_eq({5'h00, coils}, 8'h04, "coil kept");
    $display("test link done");
    for (int i = 0; i < 11; i++) begin
      partner_u.send_packet(wpt_pkg::HDR_CTRL_ERR, rows[i][15:8], 1'b0);
      n = 0;
      while (freq_khz !== rows[i][7:0] && n < 64) begin
        @(negedge clk);
        n++;
      end
      expect_eq(freq_khz, rows[i][7:0], "control step");
    end
    partner_u.send_packet(wpt_pkg::HDR_CTRL_ERR, 8'h10, 1'b1);
    wait_phase(wpt_pkg::PH_SELECT, 200, n);
    $display("test control done");
    ans_mask = 3'h1;
    wait_phase(wpt_pkg::PH_PING, 10000, n);
    expect_eq({5'h00, coils}, 8'h01, "first coil answers");
    wait_phase(wpt_pkg::PH_SELECT, 8000, n);
    expect_eq({7'h00, n >= 3995 && n <= 4010}, 8'h01, "ping delay");
    $display("test ping timeout done");
    wait_phase(wpt_pkg::PH_PING, 10000, n);
    over_temp_hi = 1'b1;
    temp_below_lo = 1'b0;
    wait_phase(wpt_pkg::PH_HOT, 20, n);
    expect_eq({5'h00, coils}, 8'h00, "coils off when hot");
    over_temp_hi = 1'b0;
    repeat (50) @(negedge clk);
    expect_eq({5'h00, phase}, {5'h00, wpt_pkg::PH_HOT}, "hysteresis");
    temp_below_lo = 1'b1;
    wait_phase(wpt_pkg::PH_SELECT, 20, n);
    expect_eq({5'h00, coils}, 8'h00, "coils off on recovery");
    $display("test thermal done");
    ext_reset = 1'b1;
    wait_phase(wpt_pkg::PH_OFF, 10, n);
    expect_eq({7'h00, sleep}, 8'h01, "defaults on reset");
    ext_reset = 1'b0;
    wait_phase(wpt_pkg::PH_BOOT, 20, n);
    n = 0;
    while (sda_oe !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    expect_eq({7'h00, sda_oe}, 8'h01, "memory fetch starts");
    $display("test external reset done");
    enable_n = 1'b1;
    repeat (10) @(negedge clk);
    expect_eq({7'h00, sleep}, 8'h01, "sleep when disabled");
    enable_n = 1'b0;
    repeat (10) @(negedge clk);
    expect_eq({7'h00, sleep}, 8'h00, "awake when enabled");
    $display("test sleep done");
    print_verdict;
  end
endmodule // wpt_phase_ctrl_test
bind wpt_phase_ctrl wpt_phase_ctrl_checker chk_u (
  .clk, .rst_n, .ext_reset, .enable_n, .over_temp_hi, .power_up_en,
  .sleep, .coil_select_first, .coil_select_second, .coil_select_third,
  .freq_khz, .duty, .scl_o, .sda_o, .phase);
`default_nettype wire
